/* File: src/als_pkg.sv */
// Shared constants, types and helper functions for the light sensor control block.
package als_pkg;
    localparam int unsigned CLK_KHZ       = 40000;
    localparam int unsigned T_SHORT_MS    = 100;
    localparam int unsigned T_LONG_MS     = 800;
    localparam int unsigned T_OVERHEAD_MS = 3;
    localparam int unsigned T_ASSESS_MS   = 10;
    localparam int unsigned T_HANG_MS     = 28;
    localparam int unsigned SHORT_CYC     = T_SHORT_MS * CLK_KHZ;
    localparam int unsigned LONG_CYC      = T_LONG_MS * CLK_KHZ;
    localparam int unsigned OVH_CYC       = T_OVERHEAD_MS * CLK_KHZ;
    localparam int unsigned ASSESS_CYC    = T_ASSESS_MS * CLK_KHZ;
    localparam int unsigned HANG_CYC      = T_HANG_MS * CLK_KHZ;
    localparam int          CNT_W         = 26;

    localparam logic [6:0]  DEV_ADDR      = 7'h44;
    localparam logic [3:0]  RANGE_AUTO    = 4'hC;
    localparam logic [3:0]  RANGE_MAX     = 4'hB;
    localparam logic [1:0]  MODE_OFF      = 2'h0;
    localparam logic [1:0]  MODE_SINGLE   = 2'h1;

    localparam logic [7:0]  REG_CFG       = 8'h00;
    localparam logic [7:0]  REG_RESULT    = 8'h04;
    localparam logic [7:0]  REG_LOW       = 8'h08;
    localparam logic [7:0]  REG_HIGH      = 8'h0C;
    localparam logic [7:0]  REG_STATUS    = 8'h10;
    localparam logic [7:0]  REG_MASK      = 8'h14;

    localparam int          CFG_MODE_LSB  = 0;
    localparam int          CFG_LONG_BIT  = 2;
    localparam int          CFG_RANGE_LSB = 3;
    localparam int          CFG_LEVEL_BIT = 7;
    localparam logic [15:0] CFG_RST       = 16'h0060;
    localparam logic [15:0] LOW_RST       = 16'h0000;
    localparam logic [15:0] HIGH_RST      = 16'hBFFF;

    localparam int          ST_W          = 4;
    localparam int          ST_DONE       = 0;
    localparam int          ST_HIGH       = 1;
    localparam int          ST_LOW        = 2;
    localparam int          ST_HANG       = 3;

    typedef enum logic [2:0] {C_IDLE = 3'h1, C_ASSESS = 3'h2, C_INTEG = 3'h4} conv_state_t;
    typedef enum logic [7:0] {I_IDLE = 8'h01, I_ADDR = 8'h02, I_ADEC = 8'h04, I_ACK = 8'h08,
                              I_TX = 8'h10, I_MACK = 8'h20, I_RX = 8'h40, I_WACK = 8'h80} bus_state_t;

    // Smallest exponent that keeps the mantissa within twelve bits.
    function automatic logic [3:0] range_pick(input logic [22:0] lvl);
        logic [3:0] e;
        e = RANGE_MAX;
        for (int i = 11; i >= 0; i--) begin
            if ((lvl >> i) < 23'h001000) begin
                e = 4'(i);
            end
        end
        return e;
    endfunction

    function automatic logic [11:0] mant_of(input logic [22:0] lvl, input logic [3:0] e);
        logic [22:0] m;
        m = lvl >> e;
        return (m > 23'h000FFF) ? 12'hFFF : m[11:0];
    endfunction

    function automatic logic [22:0] to_lux(input logic [15:0] r);
        logic [22:0] m;
        m = {11'h000, r[11:0]} << r[15:12];
        return m;
    endfunction
endpackage

/* File: src/bus_watch.sv */
// Serial pin synchroniser, start/stop and edge detection, and clock-held-low watchdog.
`timescale 1ns/1ps
module bus_watch #(
    parameter int unsigned HANG_CYC = als_pkg::HANG_CYC
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic resetn,
    // Bus pins
    input  wire logic scl_in,
    input  wire logic sda_in,
    // Conditioned bus events
    output logic      scl_s,
    output logic      sda_s,
    output logic      start,
    output logic      stop,
    output logic      rise,
    output logic      fall,
    output logic      hang
);
    import als_pkg::*;

    typedef struct packed {
        logic [1:0]       s1;
        logic [1:0]       s2;
        logic [1:0]       pv;
        logic [CNT_W-1:0] cnt;
        logic             hang;
    } watch_t;

    watch_t w_r;
    watch_t w_nxt;

    always_comb begin
        w_nxt      = w_r;
        w_nxt.s1   = {scl_in, sda_in};
        w_nxt.s2   = w_r.s1;
        w_nxt.pv   = w_r.s2;
        w_nxt.hang = 1'b0;
        if (w_r.s2[1]) begin
            w_nxt.cnt = '0;
        end else if (w_r.cnt != CNT_W'(HANG_CYC - 1)) begin
            w_nxt.cnt  = w_r.cnt + 1'b1;
            w_nxt.hang = (w_r.cnt == CNT_W'(HANG_CYC - 2));  // [R01]
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            w_r <= '{s1: 2'h3, s2: 2'h3, pv: 2'h3, cnt: '0, hang: 1'b0};
        end else begin
            w_r <= w_nxt;
        end
    end

    assign scl_s = w_r.s2[1];
    assign sda_s = w_r.s2[0];
    assign rise  = w_r.s2[1] & ~w_r.pv[1];
    assign fall  = ~w_r.s2[1] & w_r.pv[1];
    assign start = w_r.s2[1] & w_r.pv[1] & w_r.pv[0] & ~w_r.s2[0];
    assign stop  = w_r.s2[1] & w_r.pv[1] & ~w_r.pv[0] & w_r.s2[0];
    assign hang  = w_r.hang;

    hang_after_low_a: assert property (@(posedge mclk) disable iff (!resetn) // [R01]
        hang |-> (w_r.cnt == CNT_W'(HANG_CYC - 1) && $past(!scl_s)))
        else $error("Bus hang flagged without the clock held low long enough.");
endmodule // bus_watch

/* File: src/conv_seq.sv */
// Conversion sequencer: shutdown, single-shot and continuous timing with automatic ranging.
`timescale 1ns/1ps
module conv_seq #(
    parameter int unsigned SHORT_CYC  = als_pkg::SHORT_CYC,
    parameter int unsigned LONG_CYC   = als_pkg::LONG_CYC,
    parameter int unsigned OVH_CYC    = als_pkg::OVH_CYC,
    parameter int unsigned ASSESS_CYC = als_pkg::ASSESS_CYC
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        resetn,
    // Configuration
    input  wire logic [1:0]  mode,
    input  wire logic        long_sel,
    input  wire logic [3:0]  range_select_field,
    // Front end level
    input  wire logic [22:0] light_level,
    // Measurement result
    output logic [15:0]      result,
    output logic             done,
    output logic             busy
);
    import als_pkg::*;

    typedef struct packed {
        conv_state_t      st;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] age;
        logic [3:0]       expo;
        logic [15:0]      res;
        logic             done;
    } seq_t;

    seq_t s_r;
    seq_t s_nxt;
    logic [CNT_W-1:0] load;

    always_comb begin
        load = long_sel ? CNT_W'(LONG_CYC + OVH_CYC - 1) : CNT_W'(SHORT_CYC + OVH_CYC - 1);  // [R02] [R08]
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        s_nxt.cnt  = s_r.cnt - 1'b1;
        s_nxt.age  = s_r.age + 1'b1;
        unique case (s_r.st)
            C_IDLE: begin
                s_nxt.cnt = s_r.cnt;
                // The cycle after a done still sees the old mode, so a finished single shot must not restart.
                if (mode != MODE_OFF && !s_r.done) begin  // [R03]
                    if (range_select_field == RANGE_AUTO) begin  // [R09]
                        s_nxt.st  = C_ASSESS;  // [R10]
                        s_nxt.cnt = CNT_W'(ASSESS_CYC - 1);
                    end else begin
                        s_nxt.st   = C_INTEG;
                        s_nxt.expo = (range_select_field > RANGE_MAX) ? RANGE_MAX : range_select_field;
                        s_nxt.cnt  = load;
                        s_nxt.age  = '0;
                    end
                end
            end
            C_ASSESS: begin
                if (s_r.cnt == '0) begin
                    s_nxt.st   = C_INTEG;
                    s_nxt.expo = range_pick(light_level);  // [R10]
                    s_nxt.cnt  = load;
                    s_nxt.age  = '0;
                end
            end
            C_INTEG: begin
                if (s_r.cnt == '0) begin
                    s_nxt.res  = {s_r.expo, mant_of(light_level, s_r.expo)};  // [R06]
                    s_nxt.done = 1'b1;
                    if (range_select_field == RANGE_AUTO) begin
                        s_nxt.expo = range_pick(light_level);  // [R05]
                    end
                    if (mode == MODE_SINGLE) begin  // [R04]
                        s_nxt.st = C_IDLE;
                    end else begin
                        s_nxt.cnt = load;
                        s_nxt.age = '0;
                    end
                end
            end
        endcase
        if (mode == MODE_OFF) begin
            s_nxt.st   = C_IDLE;  // [R03]
            s_nxt.done = 1'b0;
            s_nxt.res  = s_r.res;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_r <= '{st: C_IDLE, cnt: '0, age: '0, expo: 4'h0, res: 16'h0000, done: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign result = s_r.res;
    assign done   = s_r.done;
    assign busy   = (s_r.st != C_IDLE);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    conv_time_a: assert property ($rose(done) |-> // [R08]
        ($past(s_r.age) == CNT_W'(SHORT_CYC + OVH_CYC - 1) || $past(s_r.age) == CNT_W'(LONG_CYC + OVH_CYC - 1)))
        else $error("Result ready at a time other than integration plus overhead.");
    shutdown_quiet_a: assert property ((mode == MODE_OFF) |=> !busy && !done) // [R03]
        else $error("Conversion activity while in shutdown.");
    auto_assess_a: assert property ((s_r.st == C_IDLE && mode != MODE_OFF && !done && range_select_field == RANGE_AUTO) // [R10]
        |=> s_r.st == C_ASSESS && s_r.cnt == CNT_W'(ASSESS_CYC - 1))
        else $error("Auto ranging did not start with a range assessment.");
endmodule // conv_seq

/* File: src/light_sensor_measure_control.sv */
// Top of the light sensor control: registers, serial target, window alert and interrupt.
// Summary of operation
// R01: Serial clock held low for the hang timeout resets the serial state machine.
// R02: Each measurement integrates over a short or a long selectable period.
// R03: After reset the block sits in shutdown and converts nothing until commanded.
// R04: Host selects continuous or single-shot conversions; sequencing follows the selected mode.
// R05: Automatic ranging picks the full-scale range itself between measurements.
// R06: Each completed result is readable as a lux word over the serial bus.
// R07: Each result is compared to a programmable window and drives the alert pin.
// R08: Result becomes readable after integration time plus a fixed overhead.
// R09: Range field code 1100b selects automatic ranging; other codes are fixed ranges.
// R10: Automatic ranging starts with a short range assessment measurement.
// R11: Alert level 0 pulls the pin low when active; level 1 releases it.
// R12: After a hang timeout the serial target ignores the bus until a start.
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module light_sensor_measure_control #(
    parameter int unsigned SHORT_CYC  = als_pkg::SHORT_CYC,
    parameter int unsigned LONG_CYC   = als_pkg::LONG_CYC,
    parameter int unsigned OVH_CYC    = als_pkg::OVH_CYC,
    parameter int unsigned ASSESS_CYC = als_pkg::ASSESS_CYC,
    parameter int unsigned HANG_CYC   = als_pkg::HANG_CYC,
    parameter logic [6:0]  BUS_ADDR   = als_pkg::DEV_ADDR
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        resetn,
    // Register port
    input  wire logic [7:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [15:0]      rdata,
    // Front end level
    input  wire logic [22:0] light_level,
    // Two-wire bus pins
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_n,
    // Alert pin and interrupt
    output logic             alert_out,
    output logic             alert_oe_n,
    output logic             irq
);
    import als_pkg::*;

    typedef struct packed {
        logic [15:0]     cfg;
        logic [15:0]     lo;
        logic [15:0]     hi;
        logic [ST_W-1:0] status;
        logic [ST_W-1:0] mask;
        logic [15:0]     rdata;
        logic            irq;
        logic            alert_act;
        logic            alert_oe_n;
        logic            alert_out;
        bus_state_t      bst;
        logic [2:0]      bits;
        logic [7:0]      sh;
        logic            rw;
        logic            bsel;
        logic [15:0]     snap;
        logic            sda_oe_n;
        logic            sda_out;
    } top_t;

    top_t s_r;
    top_t s_nxt;

    logic        scl_s;
    logic        sda_s;
    logic        start;
    logic        stop;
    logic        rise;
    logic        fall;
    logic        hang;
    logic [15:0] result;
    logic        done;
    logic        busy;

    logic [22:0]     lux;
    logic            hi_f;
    logic            lo_f;
    logic [ST_W-1:0] ev;
    logic [ST_W-1:0] rd_clr;

    bus_watch #(
        .HANG_CYC (HANG_CYC)
    ) u_watch (
        .mclk   (mclk),
        .resetn (resetn),
        .scl_in (scl_in),
        .sda_in (sda_in),
        .scl_s  (scl_s),
        .sda_s  (sda_s),
        .start  (start),
        .stop   (stop),
        .rise   (rise),
        .fall   (fall),
        .hang   (hang)
    );

    conv_seq #(
        .SHORT_CYC  (SHORT_CYC),
        .LONG_CYC   (LONG_CYC),
        .OVH_CYC    (OVH_CYC),
        .ASSESS_CYC (ASSESS_CYC)
    ) u_seq (
        .mclk               (mclk),
        .resetn             (resetn),
        .mode               (s_r.cfg[CFG_MODE_LSB +: 2]),
        .long_sel           (s_r.cfg[CFG_LONG_BIT]),
        .range_select_field (s_r.cfg[CFG_RANGE_LSB +: 4]),
        .light_level        (light_level),
        .result             (result),
        .done               (done),
        .busy               (busy)
    );

    always_comb begin
        s_nxt       = s_r;
        s_nxt.rdata = 16'h0000;
        lux         = to_lux(result);
        hi_f        = lux > to_lux(s_r.hi);  // [R07]
        lo_f        = lux < to_lux(s_r.lo);  // [R07]
        ev          = '0;
        ev[ST_DONE] = done;
        ev[ST_HIGH] = done & hi_f;
        ev[ST_LOW]  = done & lo_f;
        ev[ST_HANG] = hang;
        rd_clr      = (rd && addr == REG_STATUS) ? '1 : '0;

        if (wr) begin
            case (addr)
                REG_CFG:  s_nxt.cfg  = wdata;
                REG_LOW:  s_nxt.lo   = wdata;
                REG_HIGH: s_nxt.hi   = wdata;
                REG_MASK: s_nxt.mask = wdata[ST_W-1:0];
                default:  ;
            endcase
        end
        if (rd) begin
            case (addr)
                REG_CFG:    s_nxt.rdata = s_r.cfg;
                REG_RESULT: s_nxt.rdata = result;  // [R06]
                REG_LOW:    s_nxt.rdata = s_r.lo;
                REG_HIGH:   s_nxt.rdata = s_r.hi;
                REG_STATUS: s_nxt.rdata = {12'h000, s_r.status};
                REG_MASK:   s_nxt.rdata = {12'h000, s_r.mask};
                default:    s_nxt.rdata = 16'h0000;
            endcase
        end

        // A status event in the same cycle as the clearing read survives.
        s_nxt.status = (s_r.status & ~rd_clr) | ev;

        // Single-shot hands back to shutdown once its result lands, even over a racing write.
        if (done && s_r.cfg[CFG_MODE_LSB +: 2] == MODE_SINGLE) begin
            s_nxt.cfg[CFG_MODE_LSB +: 2] = MODE_OFF;  // [R04]
        end

        // Transparent window: the alert follows the latest result.
        if (done) begin
            s_nxt.alert_act = hi_f | lo_f;  // [R07]
        end
        s_nxt.alert_oe_n = ~(s_nxt.alert_act ^ s_nxt.cfg[CFG_LEVEL_BIT]);  // [R11]
        s_nxt.alert_out  = 1'b0;
        s_nxt.irq        = |(s_nxt.status & s_nxt.mask);
        s_nxt.sda_out    = 1'b0;

        if (hang || stop) begin
            s_nxt.bst      = I_IDLE;  // [R01]
            s_nxt.sda_oe_n = 1'b1;
        end else if (start) begin
            s_nxt.bst      = I_ADDR;  // [R12]
            s_nxt.bits     = 3'h0;
            s_nxt.sda_oe_n = 1'b1;
        end else begin
            unique case (s_r.bst)
                I_IDLE: begin
                    s_nxt.bst = I_IDLE;  // [R12]
                end
                I_ADDR, I_RX: begin
                    if (rise) begin
                        s_nxt.sh   = {s_r.sh[6:0], sda_s};
                        s_nxt.bits = s_r.bits + 3'h1;
                        if (s_r.bits == 3'h7) begin
                            s_nxt.bst = (s_r.bst == I_ADDR) ? I_ADEC : I_WACK;
                        end
                    end
                end
                I_ADEC: begin
                    if (fall) begin
                        if (s_r.sh[7:1] == BUS_ADDR) begin
                            s_nxt.sda_oe_n = 1'b0;
                            s_nxt.rw       = s_r.sh[0];
                            s_nxt.snap     = result;  // [R06]
                            s_nxt.bsel     = 1'b0;
                            s_nxt.bst      = I_ACK;
                        end else begin
                            s_nxt.bst = I_IDLE;
                        end
                    end
                end
                I_WACK: begin
                    if (fall) begin
                        s_nxt.sda_oe_n = 1'b0;
                        s_nxt.rw       = 1'b0;
                        s_nxt.bst      = I_ACK;
                    end
                end
                I_ACK: begin
                    if (fall) begin
                        s_nxt.bits = 3'h0;
                        if (s_r.rw) begin
                            s_nxt.sh       = s_r.bsel ? s_r.snap[7:0] : s_r.snap[15:8];  // [R06]
                            s_nxt.bsel     = ~s_r.bsel;
                            s_nxt.sda_oe_n = s_nxt.sh[7];
                            s_nxt.bst      = I_TX;
                        end else begin
                            s_nxt.sda_oe_n = 1'b1;
                            s_nxt.bst      = I_RX;
                        end
                    end
                end
                I_TX: begin
                    if (fall) begin
                        if (s_r.bits == 3'h7) begin
                            s_nxt.sda_oe_n = 1'b1;
                            s_nxt.bst      = I_MACK;
                        end else begin
                            s_nxt.sh       = {s_r.sh[6:0], 1'b0};
                            s_nxt.sda_oe_n = s_r.sh[6];
                            s_nxt.bits     = s_r.bits + 3'h1;
                        end
                    end
                end
                I_MACK: begin
                    if (rise) begin
                        s_nxt.bst = sda_s ? I_IDLE : I_ACK;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_r <= '{cfg: CFG_RST, lo: LOW_RST, hi: HIGH_RST, status: '0, mask: '0, rdata: 16'h0000,
                     irq: 1'b0, alert_act: 1'b0, alert_oe_n: 1'b1, alert_out: 1'b0, bst: I_IDLE,
                     bits: 3'h0, sh: 8'h00, rw: 1'b0, bsel: 1'b0, snap: 16'h0000, sda_oe_n: 1'b1,
                     sda_out: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata      = s_r.rdata;
    assign sda_out    = s_r.sda_out;
    assign sda_oe_n   = s_r.sda_oe_n;
    assign alert_out  = s_r.alert_out;
    assign alert_oe_n = s_r.alert_oe_n;
    assign irq        = s_r.irq;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    sequence hang_seen;
        hang;
    endsequence

    sequence quiet_idle;
        s_r.bst == I_IDLE && !start;
    endsequence

    hang_reset_a: assert property (hang_seen |=> s_r.bst == I_IDLE && s_r.sda_oe_n) // [R01]
        else $error("Serial state machine not reset after clock hang.");
    idle_until_start_a: assert property (quiet_idle |=> s_r.bst == I_IDLE && s_r.sda_oe_n) // [R12]
        else $error("Serial target left idle without a start condition.");
    alert_level_a: assert property ((done && (hi_f || lo_f) && !wr) |=> // [R11]
        s_r.alert_act && s_r.alert_oe_n == s_r.cfg[CFG_LEVEL_BIT])
        else $error("Alert pin does not reflect the active level after a window fault.");
    single_stop_a: assert property ((done && s_r.cfg[CFG_MODE_LSB +: 2] == MODE_SINGLE) |=> // [R04]
        (s_r.cfg[CFG_MODE_LSB +: 2] == MODE_OFF && !busy) [*2])
        else $error("Single-shot conversion did not return to shutdown.");
    first_bit_a: assert property ((s_r.bst == I_ACK && fall && s_r.rw && !s_r.bsel && !hang && !stop && !start) // [R06]
        |=> s_r.bst == I_TX && s_r.sda_oe_n == s_r.snap[15])
        else $error("First result bit on the bus does not match the captured result.");
endmodule // light_sensor_measure_control

/* File: sim/bus_ctl.sv */
// Two-wire bus controller model that reads result bytes and can hang the clock.
`timescale 1ns/1ps
module bus_ctl (
    // Bus pins
    output logic      scl,
    output logic      sda_m,
    input  wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    // Data moves well inside the low phase so it is never mistaken for a start or stop.
    task automatic bit_io(input logic b, output logic s);
        #50 sda_m = b;
        #50 scl = 1'b1;
        #100 s = sda;
        scl = 1'b0;
    endtask
    task automatic rd_frame(input logic st, input logic [6:0] a, input logic rw, output logic ack,
                            output logic [15:0] d);
        logic s;
        if (st) begin
            sda_m = 1'b0;
            #100 scl = 1'b0;
        end
        for (int i = 7; i >= 0; i--) bit_io((i > 0) ? a[i-1] : rw, s);
        bit_io(1'b1, s);
        ack = ~s;
        for (int i = 15; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
            if (i == 8) bit_io(1'b0, s);
        end
        bit_io(1'b1, s);
        #50 sda_m = 1'b0;
        #50 scl = 1'b1;
        #100 sda_m = 1'b1;
        #200;
    endtask
    // A start comes first so that the watchdog has a frame in progress to abandon.
    task automatic hold_low(input int ns);
        sda_m = 1'b0;
        #100 scl = 1'b0;
        #(ns) sda_m = 1'b1;
        #100 scl = 1'b1;
        #200;
    endtask
endmodule // bus_ctl

/* File: sim/tb_top.sv */
// Self-checking bench for the light sensor control block.
`timescale 1ns/1ps
module tb_top;
    import als_pkg::*;
    typedef struct {logic [7:0] a; logic w; logic [15:0] d;} row_t;
    logic        mclk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [15:0] wdata = 16'h0000, rdata, v;
    logic [22:0] lvl = 23'h000123;
    logic        scl, sda_m, sda_out, sda_oe_n, alert_out, alert_oe_n, irq, ack;
    wire         sda = sda_m & (sda_oe_n | sda_out);
    int          n_mismatch = 0, total_checks = 0;
    row_t        rows [12] = '{'{REG_CFG, 1'b0, CFG_RST}, '{REG_LOW, 1'b0, LOW_RST},
        '{REG_HIGH, 1'b0, HIGH_RST}, '{REG_STATUS, 1'b0, 16'h0000}, '{REG_MASK, 1'b0, 16'h0000},
        '{8'hFC, 1'b1, 16'h1234}, '{8'hFC, 1'b0, 16'h0000}, '{REG_MASK, 1'b1, 16'h0001},
        '{REG_MASK, 1'b0, 16'h0001}, '{REG_LOW, 1'b1, 16'h0010}, '{REG_LOW, 1'b0, 16'h0010},
        '{REG_RESULT, 1'b1, 16'hFFFF}};
    light_sensor_measure_control #(.SHORT_CYC(200), .LONG_CYC(400), .OVH_CYC(30), .ASSESS_CYC(20),
        .HANG_CYC(500)) light_sensor_measure_control_i (.mclk(mclk), .resetn(resetn), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .light_level(lvl), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .alert_out(alert_out), .alert_oe_n(alert_oe_n), .irq(irq));
    bus_ctl bus_ctl_i (.scl(scl), .sda_m(sda_m), .sda(sda));
    always #12.5 mclk = ~mclk;
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(negedge mclk);
        chk($sformatf("reg %h", a), e, rdata & m);
    endtask
    // The window allows for the sequencer leaving idle and the registered interrupt output.
    task automatic wait_irq(input int nom);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < nom + 20) begin
            @(posedge mclk);
            n++;
        end
        chk("irq delay", 16'h0001, {15'h0, (n >= nom - 4) && (n <= nom + 6)});
        if (n >= nom + 20) summarize();
    endtask
    task automatic conv(input logic [15:0] c, input int nom, input logic [15:0] res, input logic oe);
        wreg(REG_CFG, c);
        wait_irq(nom);
        rchk(REG_STATUS, 16'h0001, 16'h0001);
        rchk(REG_RESULT, 16'hFFFF, res);
        chk("alert", {15'h0, oe}, {15'h0, alert_oe_n});
        chk("alert drive", 16'h0000, {15'h0, alert_out});
        $display("conversion %h done", c);
    endtask
    initial begin
        #200000;
        n_mismatch++;
        summarize();
    end
    initial begin
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w) wreg(rows[i].a, rows[i].d);
            else rchk(rows[i].a, 16'hFFFF, rows[i].d);
        end
        chk("irq idle", 16'h0000, {15'h0, irq});
        repeat (300) @(posedge mclk);
        rchk(REG_STATUS, 16'hFFFF, 16'h0000);
        $display("register table done");
        conv(16'h0001, 231, 16'h0123, 1'b1);
        rchk(REG_CFG, 16'h0003, 16'h0000);
        conv(16'h0005, 431, 16'h0123, 1'b1);
        lvl <= 23'h012345;
        conv(16'h0061, 251, 16'h591A, 1'b1);
        lvl <= 23'h000123;
        wreg(REG_HIGH, 16'h0100);
        conv(16'h0001, 231, 16'h0123, 1'b0);
        conv(16'h0081, 231, 16'h0123, 1'b1);
        wreg(REG_HIGH, 16'hBFFF);
        conv(16'h0002, 231, 16'h0123, 1'b1);
        wait_irq(225);
        wreg(REG_CFG, 16'h0000);
        rchk(REG_STATUS, 16'h0001, 16'h0001);
        bus_ctl_i.rd_frame(1'b1, 7'h44, 1'b1, ack, v);
        chk("bus ack", 16'h0001, {15'h0, ack});
        chk("bus data", 16'h0123, v);
        bus_ctl_i.rd_frame(1'b1, 7'h44, 1'b0, ack, v);
        chk("write ack", 16'h0001, {15'h0, ack});
        chk("write data", 16'hFFFF, v);
        rchk(REG_CFG, 16'hFFFF, 16'h0000);
        chk("sda drive", 16'h0000, {15'h0, sda_out});
        bus_ctl_i.rd_frame(1'b1, 7'h45, 1'b1, ack, v);
        chk("other address ack", 16'h0000, {15'h0, ack});
        bus_ctl_i.hold_low(15000);
        chk("irq masked", 16'h0000, {15'h0, irq});
        rchk(REG_STATUS, 16'h0008, 16'h0008);
        bus_ctl_i.rd_frame(1'b0, 7'h44, 1'b1, ack, v);
        chk("no start ack", 16'h0000, {15'h0, ack});
        bus_ctl_i.rd_frame(1'b1, 7'h44, 1'b1, ack, v);
        chk("ack after hang", 16'h0001, {15'h0, ack});
        $display("serial bus done");
        summarize();
    end
endmodule // tb_top
